//--- pkg/egp_pkg.sv
// Constants shared by the eight-bit port block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package egp_pkg;

  // ********************************
  // Geometry and register map
  // ********************************
  localparam int EGP_WIDTH = 8;
  localparam int EGP_ADDR_W = 4;
  localparam int EGP_DATA_W = 32;
  localparam logic [EGP_ADDR_W-1:0] EGP_OFS_LATCH = 4'h0;
  localparam logic [EGP_ADDR_W-1:0] EGP_OFS_DIR = 4'h4;
  localparam logic [EGP_ADDR_W-1:0] EGP_OFS_PINS = 4'h8;
  localparam int EGP_LANE0 = 0;

  // ********************************
  // Reset and readback values
  // ********************************
  localparam logic EGP_LATCH_RST = 1'b0;
  localparam logic EGP_DIR_RST = 1'b0;
  localparam logic EGP_WO_BIT = 1'b1;
  localparam logic EGP_DIR_IN = 1'b0;
  localparam logic EGP_DIR_OUT = 1'b1;
  localparam logic EGP_SYNC_RST = 1'b0;

  // ********************************
  // Bus handshake states
  // ********************************
  typedef enum logic [1:0] {
    EGP_ST_IDLE = 2'b01,
    EGP_ST_ACK = 2'b10
  } egp_bus_state_t;

endpackage

//--- rtl/egp_sync.sv
// Two-flop synchroniser for the port pins.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module egp_sync
  import egp_pkg::*;
#(
  parameter int WIDTH = EGP_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);

  // ********************************
  // Synchroniser stages
  // ********************************
  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {WIDTH{EGP_SYNC_RST}};
      sync_out <= {WIDTH{EGP_SYNC_RST}};
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

//--- rtl/egp_bit_cell.sv
// One port bit: output latch, direction bit and read selection.
// Assumes write strobes are one-cycle pulses from the bus logic.
`timescale 1ns/1ps
`default_nettype none
module egp_bit_cell
  import egp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic wdata_bit,
  input wire logic pin_sync,
  output var logic pin_out,
  output var logic pin_oe,
  output logic rd_bit
);

  // ********************************
  // Storage
  // ********************************
  // Latch takes every write, whatever the direction
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= EGP_LATCH_RST;
    end else if (wr_latch) begin
      pin_out <= wdata_bit;
    end
  end

  // Direction bit doubles as the pin driver enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe <= EGP_DIR_RST;
    end else if (wr_dir) begin
      pin_oe <= wdata_bit;
    end
  end

  // ********************************
  // Read selection
  // ********************************
  // Output bits show the latch, input bits the pin level
  assign rd_bit = (pin_oe == EGP_DIR_OUT) ? pin_out : pin_sync;

endmodule
`default_nettype wire

//--- rtl/egp_port.sv
// Eight-bit general-purpose port with an Avalon-MM slave.
// Assumes core_clk at 25 MHz and pins driven from outside the chip.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module egp_port
  import egp_pkg::*;
#(
  parameter int WIDTH = EGP_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [EGP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [EGP_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output var logic [EGP_DATA_W-1:0] avs_readdata,
  output var logic avs_waitrequest,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);

  // ********************************
  // Decode helper
  // ********************************
  // Used by both the read and the write path
  function automatic logic reg_hit(
    input logic [EGP_ADDR_W-1:0] addr,
    input logic [EGP_ADDR_W-1:0] ofs
  );
    reg_hit = (addr == ofs);
  endfunction

  // ********************************
  // Declarations
  // ********************************
  egp_bus_state_t state_ff;
  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] rd_bits;
  logic [WIDTH-1:0] nxt_rbyte;
  logic req;
  logic in_ack;
  logic wr_latch_en;
  logic wr_dir_en;
  logic lane0;

  assign req = avs_read | avs_write;
  assign in_ack = (state_ff == EGP_ST_ACK);
  assign lane0 = avs_byteenable[EGP_LANE0];

  // ********************************
  // Pin synchroniser
  // ********************************
  egp_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ********************************
  // Bit cells
  // ********************************
  // Same index selects latch, direction and pin
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      egp_bit_cell u_cell (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_latch(wr_latch_en),
        .wr_dir(wr_dir_en),
        .wdata_bit(avs_writedata[gi]),
        .pin_sync(pin_sync[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi]),
        .rd_bit(rd_bits[gi])
      );
    end
  endgenerate

  // ********************************
  // Bus handshake
  // ********************************
  // One wait cycle for every access keeps read data in a flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= EGP_ST_IDLE;
    end else begin
      unique case (state_ff)
        EGP_ST_IDLE: begin
          if (req) begin
            state_ff <= EGP_ST_ACK;
          end
        end
        EGP_ST_ACK: begin
          state_ff <= EGP_ST_IDLE;
        end
        default: begin
          state_ff <= EGP_ST_IDLE;
        end
      endcase
    end
  end

  // Waitrequest stays high while idle, low only in the answer cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(state_ff == EGP_ST_IDLE && req);
    end
  end

  // ********************************
  // Write strobes
  // ********************************
  // Writes land on the edge where waitrequest is seen low
  assign wr_latch_en = in_ack && avs_write && lane0 &&
    reg_hit(avs_address, EGP_OFS_LATCH);
  assign wr_dir_en = in_ack && avs_write && lane0 &&
    reg_hit(avs_address, EGP_OFS_DIR);

  // ********************************
  // Read path
  // ********************************
  // Direction reads as ones, so a blind bit clear there flips inputs
  always_comb begin
    nxt_rbyte = '0;
    if (reg_hit(avs_address, EGP_OFS_LATCH)) begin
      nxt_rbyte = rd_bits;
    end else if (reg_hit(avs_address, EGP_OFS_DIR)) begin
      nxt_rbyte = {WIDTH{EGP_WO_BIT}};
    end else if (reg_hit(avs_address, EGP_OFS_PINS)) begin
      nxt_rbyte = pin_sync;
    end
  end

  // Read data captured as the answer cycle begins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (state_ff == EGP_ST_IDLE && avs_read) begin
      avs_readdata <= {{(EGP_DATA_W-WIDTH){1'b0}}, nxt_rbyte};
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic rd_take;
  assign rd_take = (state_ff == EGP_ST_IDLE) && avs_read;

  chk_read_inputs: assert property (
    rd_take && reg_hit(avs_address, EGP_OFS_LATCH)
    |=> ((avs_readdata[WIDTH-1:0] & ~$past(pin_oe)) ==
         ($past(pin_sync) & ~$past(pin_oe))))
    else $error("input bit read not pin level");

  chk_read_outputs: assert property (
    rd_take && reg_hit(avs_address, EGP_OFS_LATCH)
    |=> ((avs_readdata[WIDTH-1:0] & $past(pin_oe)) ==
         ($past(pin_out) & $past(pin_oe))))
    else $error("output bit read not latch value");

  chk_dir_reads_ones: assert property (
    rd_take && reg_hit(avs_address, EGP_OFS_DIR)
    |=> (avs_readdata[WIDTH-1:0] == {WIDTH{EGP_WO_BIT}}))
    else $error("direction read not all ones");

  chk_dir_release: assert property (
    wr_dir_en |=> ((pin_oe | $past(avs_writedata[WIDTH-1:0])) ==
                   $past(avs_writedata[WIDTH-1:0])))
    else $error("input bit still driven");

  chk_dir_drive: assert property (
    wr_dir_en |=> ((pin_oe & $past(avs_writedata[WIDTH-1:0])) ==
                   $past(avs_writedata[WIDTH-1:0])))
    else $error("output bit not driven");

  chk_out_level: assert property (
    wr_latch_en ##1 (!wr_latch_en)[*2]
    |-> ((pin_out & pin_oe) == ($past(avs_writedata[WIDTH-1:0], 3) & pin_oe)))
    else $error("driven level differs from latch");

  chk_latch_all_bits: assert property (
    wr_latch_en |=> (pin_out == $past(avs_writedata[WIDTH-1:0])))
    else $error("latch write lost bits");

  chk_dir_keeps_latch: assert property (
    wr_dir_en && !wr_latch_en |=> $stable(pin_out))
    else $error("direction write touched latch");

  chk_wait_one: assert property (
    (state_ff == EGP_ST_IDLE) && req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest timing wrong");

  chk_idle_waits: assert property (
    (state_ff == EGP_ST_IDLE) && !req |=> avs_waitrequest)
    else $error("waitrequest low without request");

  chk_state_onehot: assert property (
    $onehot(state_ff))
    else $error("handshake state not one-hot");

  // A dropped lane must leave both registers alone
  chk_lane_off: assert property (
    in_ack && avs_write && !lane0 |=> $stable(pin_out) && $stable(pin_oe))
    else $error("write without lane changed port");

  chk_pins_read: assert property (
    rd_take && reg_hit(avs_address, EGP_OFS_PINS)
    |=> (avs_readdata[WIDTH-1:0] == $past(pin_sync)))
    else $error("pin level read wrong");

  chk_unmapped_zero: assert property (
    rd_take && !reg_hit(avs_address, EGP_OFS_LATCH) && !reg_hit(avs_address, EGP_OFS_DIR)
    && !reg_hit(avs_address, EGP_OFS_PINS) |=> (avs_readdata == '0))
    else $error("unmapped read not zero");

  chk_rdata_upper: assert property (
    avs_readdata[EGP_DATA_W-1:WIDTH] == '0)
    else $error("read data upper bits not zero");

  // Read data must not drift between reads
  chk_rdata_holds: assert property (
    !rd_take |=> $stable(avs_readdata))
    else $error("read data changed without read");

  cov_latch_write: cover property (wr_latch_en);
  cov_dir_read: cover property (rd_take && reg_hit(avs_address, EGP_OFS_DIR));
  cov_mixed_read: cover property (
    rd_take && reg_hit(avs_address, EGP_OFS_LATCH) && (pin_oe != '0) && (pin_oe != '1));
  cov_dir_write: cover property (wr_dir_en);
  cov_pins_read: cover property (rd_take && reg_hit(avs_address, EGP_OFS_PINS));

endmodule
`default_nettype wire

//--- verification/egp_pin_model.sv
// Far-side pin model: resolves each port pin from both drivers.
// Assumes the bench sets ext_lvl for every pin that the port releases.
`timescale 1ns/1ps
`default_nettype none
module egp_pin_model
  import egp_pkg::*;
(
  input wire logic [EGP_WIDTH-1:0] pin_out,
  input wire logic [EGP_WIDTH-1:0] pin_oe,
  input wire logic [EGP_WIDTH-1:0] ext_lvl,
  output logic [EGP_WIDTH-1:0] pin_lvl
);
  // ********************************
  // Wire resolution
  // ********************************
  // Driven bits follow the latch, released bits the outside level
  assign pin_lvl = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the eight-bit port block.
// Assumes egp_port answers each bus request within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import egp_pkg::*;
  // ********************************
  // Signals and instances
  // ********************************
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [EGP_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [EGP_DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [EGP_DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [EGP_WIDTH-1:0] pin_lvl;
  logic [EGP_WIDTH-1:0] pin_out;
  logic [EGP_WIDTH-1:0] pin_oe;
  logic [EGP_WIDTH-1:0] ext_lvl = '0;
  logic [EGP_DATA_W-1:0] exp_q[$];
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] lat;
  logic [7:0] dir;
  logic [7:0] ext;

  egp_port dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe));
  egp_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_lvl(pin_lvl));

  // 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // ********************************
  // Tasks
  // ********************************
  task automatic cmp(input logic [EGP_DATA_W-1:0] got, input logic [EGP_DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer, held until waitrequest is seen low; idle edge after it
  // Pin state compare: direction bits above latch bits
  task automatic cmp_pins(input logic [EGP_WIDTH-1:0] exp_oe,
      input logic [EGP_WIDTH-1:0] exp_out);
    cmp_count++;
    if ({pin_oe, pin_out} !== {exp_oe, exp_out}) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, {pin_oe, pin_out}, {exp_oe, exp_out});
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
      input logic [7:0] e);
    if (!wr) exp_q.push_back({24'h0, e});
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    // No local limit: only the watchdog may end a wait
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic print_verdict();
    // A read that never came back is a mismatch too
    if (exp_q.size() != 0) bad_count++;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Read checker pairs each answered read with the oldest expectation
  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        bad_count++;
      end else begin
        cmp(avs_readdata, exp_q.pop_front());
      end
    end
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk);
    bad_count++;
    print_verdict();
  end

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    void'($urandom(40));
    repeat (3) @(posedge core_clk);
    cmp_pins(8'h00, 8'h00);
    rst_n <= 1'b1;
    ext_lvl <= 8'h40;
    repeat (3) @(posedge core_clk);
    bus(1'b0, EGP_OFS_LATCH, 8'h00, 8'h40);
    bus(1'b0, EGP_OFS_DIR, 8'h00, 8'hff);
    bus(1'b1, EGP_OFS_DIR, 8'h3f, 8'h00);
    bus(1'b1, EGP_OFS_LATCH, 8'h80, 8'h00);
    cmp_pins(8'h3f, 8'h80);
    bus(1'b0, EGP_OFS_LATCH, 8'h00, 8'h40);
    // Bit set by read-modify-write loses the input bits' latch
    bus(1'b1, EGP_OFS_LATCH, 8'h41, 8'h00);
    cmp_pins(8'h3f, 8'h41);
    // Bit clear on the write-only register turns inputs into outputs
    bus(1'b0, EGP_OFS_DIR, 8'h00, 8'hff);
    bus(1'b1, EGP_OFS_DIR, 8'hfe, 8'h00);
    cmp_pins(8'hfe, 8'h41);
    // Shadow copy keeps untouched direction bits
    bus(1'b1, EGP_OFS_DIR, 8'h3e, 8'h00);
    cmp_pins(8'h3e, 8'h41);
    // Refused writes: no byte lane, pin register, unmapped place
    avs_byteenable <= 4'h0;
    bus(1'b1, EGP_OFS_LATCH, 8'hff, 8'h00);
    avs_byteenable <= 4'h1;
    bus(1'b1, EGP_OFS_PINS, 8'hff, 8'h00);
    bus(1'b1, 4'hc, 8'hff, 8'h00);
    bus(1'b0, 4'hc, 8'h00, 8'h00);
    cmp_pins(8'h3e, 8'h41);
    // Random directions, latches and outside levels
    for (int i = 0; i < 16; i++) begin
      dir = 8'($urandom);
      lat = 8'($urandom);
      ext = 8'($urandom);
      ext_lvl <= ext;
      bus(1'b1, EGP_OFS_DIR, dir, 8'h00);
      bus(1'b1, EGP_OFS_LATCH, lat, 8'h00);
      cmp_pins(dir, lat);
      bus(1'b0, EGP_OFS_LATCH, 8'h00, (lat & dir) | (ext & ~dir));
      bus(1'b0, EGP_OFS_PINS, 8'h00, (lat & dir) | (ext & ~dir));
    end
    print_verdict();
  end
endmodule
`default_nettype wire
